// file: brake_seq_pkg.sv
// Package for the lift brake sequencer: encodings, widths and timing.
// Assumes a 50 MHz system clock and 0.01 s timer ticks.
package brake_seq_pkg;
	localparam int unsigned CLOCK_HZ = 50000000;
	localparam int unsigned TICK_TIME_MS = 10;
	localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000 * TICK_TIME_MS;
	localparam int unsigned TICK_CNT_W = 19;
	// Wait times are in 0.01 s units; 5.00 s is 500 ticks.
	localparam int unsigned WAIT_W = 9;
	localparam logic [8:0] WAIT_MAX = 9'h1f4;
	localparam logic [8:0] WAIT_RESET = 9'h000;
	// Frequencies in 0.01 Hz units, 0 to 400 Hz.
	localparam int unsigned FREQ_W = 16;
	localparam logic [15:0] FREQ_MAX = 16'h9c40;
	// Current in percent of rated current, 0 to 200.
	localparam int unsigned CUR_W = 8;
	localparam logic [7:0] CUR_MAX = 8'hc8;
	localparam logic [1:0] ENABLE_OFF = 2'h0;
	localparam logic [1:0] ENABLE_ON = 2'h1;
	localparam logic [7:0] FUNC_CONFIRM = 8'h2c;
	localparam logic [7:0] FUNC_ERROR = 8'h14;
	localparam int unsigned NUM_INPUTS = 7;

	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_ACCEL_REL = 10'h002,
		ST_REL_WAIT = 10'h004,
		ST_CONF_ON = 10'h008,
		ST_ACC_WAIT = 10'h010,
		ST_RUN = 10'h020,
		ST_DECEL_BRK = 10'h040,
		ST_CONF_OFF = 10'h080,
		ST_STOP_WAIT = 10'h100,
		ST_TRIP = 10'h200
	} seq_state_t;
endpackage

// file: tick_bus_if.sv
// Interface carrying the 0.01 s tick between the tick source and the
// sequencer. Assumes both ends share one clock.
`timescale 1ns/1ps
interface tick_bus_if;
	logic tick;
	modport source (output tick);
	modport sink (input tick);
endinterface // tick_bus_if

// file: tick_gen.sv
// Divider producing a one-cycle pulse every 0.01 s.
// Assumes a clock at the rate given in the package.
`timescale 1ns/1ps
module tick_gen #(
	parameter int unsigned DIVIDE = brake_seq_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_en,
	input wire logic restart,
	tick_bus_if.source tb
);
	logic [brake_seq_pkg::TICK_CNT_W-1:0] cnt_reg;
	logic [brake_seq_pkg::TICK_CNT_W-1:0] cnt_next;
	localparam logic [brake_seq_pkg::TICK_CNT_W-1:0] LAST =
		brake_seq_pkg::TICK_CNT_W'(DIVIDE - 1);

	// Restart aligns the tick grid with the start of each phase.
	always_comb begin
		if (restart || cnt_reg == LAST) begin
			cnt_next = '0;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	assign tb.tick = (cnt_reg == LAST) && !restart;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= '0;
		end else if (clock_en) begin
			cnt_reg <= cnt_next;
		end
	end
endmodule // tick_gen

// file: lift_brake_sequencer.sv
// Brake sequencer for a lift drive: steers the frequency target, the
// brake release and error outputs from run, current and confirmation.
// Assumes frequency and current feedback on the same clock as the block.
// Summary of operation
// - Sequence only when enable setting is 01
// - On run, accelerate only to release frequency
// - Wait release time, then assert brake release
// - Current below threshold at release: trip, error
// - With confirm input, hold and await confirm
// - Without confirm input, skip confirmation wait
// - Wait acceleration time, then go to command
// - Run removed: decelerate to braking frequency, release off
// - With confirm, await confirm off or trip
// - Then wait stopping time, decelerate to zero
// - Confirm on inputs 1 to 7, error code 20
// - Four wait timers, zero to five seconds
`timescale 1ns/1ps
module lift_brake_sequencer #(
	parameter int unsigned TICK_DIVIDE = brake_seq_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_en,
	input wire logic [1:0] brake_enable,
	input wire logic [8:0] release_wait,
	input wire logic [8:0] accel_wait,
	input wire logic [8:0] stop_wait,
	input wire logic [8:0] confirm_wait,
	input wire logic [15:0] release_freq,
	input wire logic [15:0] braking_freq,
	input wire logic [7:0] release_current,
	input wire logic [7:0] input_func [7],
	input wire logic [6:0] input_pins,
	input wire logic run_cmd,
	input wire logic [15:0] command_freq,
	input wire logic [15:0] output_freq,
	input wire logic [7:0] output_current,
	input wire logic fault_clear,
	output logic [15:0] target_freq,
	output logic drive_on,
	output logic brake_release_out,
	output logic brake_error_out,
	output logic trip,
	output logic [9:0] seq_state
);
	tick_bus_if tbus ();
	logic [6:0] pin_meta_reg;
	logic [6:0] pin_sync_reg;
	logic confirm_assigned;
	logic brake_confirm_in;
	logic enabled;
	logic [8:0] rel_w;
	logic [8:0] acc_w;
	logic [8:0] stp_w;
	logic [8:0] cnf_w;
	logic [15:0] rel_f;
	logic [15:0] brk_f;
	brake_seq_pkg::seq_state_t state_reg;
	brake_seq_pkg::seq_state_t state_next;
	logic [8:0] wait_reg;
	logic [8:0] wait_next;
	logic restart;
	logic [15:0] target_next;
	logic release_next;
	logic error_next;

	// Wait and frequency settings beyond their range are clamped rather than rejected.
	assign rel_w = release_wait > brake_seq_pkg::WAIT_MAX ?
		brake_seq_pkg::WAIT_MAX : release_wait;
	assign acc_w = accel_wait > brake_seq_pkg::WAIT_MAX ?
		brake_seq_pkg::WAIT_MAX : accel_wait;
	assign stp_w = stop_wait > brake_seq_pkg::WAIT_MAX ?
		brake_seq_pkg::WAIT_MAX : stop_wait;
	assign cnf_w = confirm_wait > brake_seq_pkg::WAIT_MAX ?
		brake_seq_pkg::WAIT_MAX : confirm_wait;
	assign rel_f = release_freq > brake_seq_pkg::FREQ_MAX ?
		brake_seq_pkg::FREQ_MAX : release_freq;
	assign brk_f = braking_freq > brake_seq_pkg::FREQ_MAX ?
		brake_seq_pkg::FREQ_MAX : braking_freq;
	assign enabled = brake_enable == brake_seq_pkg::ENABLE_ON;

	// Pins are asynchronous; two flops before any logic sees them.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else if (clock_en) begin
			pin_meta_reg <= input_pins;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// The confirm contact is whichever input carries function 44; if
	// several do, any of them counts.
	always_comb begin
		confirm_assigned = 1'b0;
		brake_confirm_in = 1'b0;
		for (int i = 0; i < brake_seq_pkg::NUM_INPUTS; i++) begin
			if (input_func[i] == brake_seq_pkg::FUNC_CONFIRM) begin
				confirm_assigned = 1'b1;
				brake_confirm_in = brake_confirm_in | pin_sync_reg[i];
			end
		end
	end

	tick_gen #(
		.DIVIDE(TICK_DIVIDE)
	) u_tick (
		.clock(clock),
		.reset_n(reset_n),
		.clock_en(clock_en),
		.restart(restart),
		.tb(tbus.source)
	);

	always_comb begin
		state_next = state_reg;
		wait_next = wait_reg;
		restart = 1'b0;
		target_next = target_freq;
		release_next = brake_release_out;
		error_next = brake_error_out;
		if (tbus.tick && wait_reg != '1) begin
			wait_next = wait_reg + 1'b1;
		end
		unique case (state_reg)
			brake_seq_pkg::ST_IDLE: begin
				target_next = '0;
				release_next = 1'b0;
				if (run_cmd) begin
					if (enabled) begin
						state_next = brake_seq_pkg::ST_ACCEL_REL;
						target_next = rel_f;
					end else begin
						state_next = brake_seq_pkg::ST_RUN;
						target_next = command_freq;
					end
				end
			end
			brake_seq_pkg::ST_ACCEL_REL: begin
				target_next = rel_f;
				if (!run_cmd) begin
					// An aborted start zeroes the target with the state, so
					// idle never carries a stale frequency.
					state_next = brake_seq_pkg::ST_IDLE;
					target_next = '0;
				end else if (output_freq >= rel_f) begin
					state_next = brake_seq_pkg::ST_REL_WAIT;
				end
			end
			brake_seq_pkg::ST_REL_WAIT: begin
				if (wait_reg >= rel_w) begin
					if (output_current < release_current) begin
						state_next = brake_seq_pkg::ST_TRIP;
						error_next = 1'b1;
					end else begin
						release_next = 1'b1;
						state_next = confirm_assigned ?
							brake_seq_pkg::ST_CONF_ON :
							brake_seq_pkg::ST_ACC_WAIT;
					end
				end
			end
			brake_seq_pkg::ST_CONF_ON: begin
				if (brake_confirm_in) begin
					state_next = brake_seq_pkg::ST_ACC_WAIT;
				end else if (wait_reg >= cnf_w) begin
					state_next = brake_seq_pkg::ST_TRIP;
					error_next = 1'b1;
				end
			end
			brake_seq_pkg::ST_ACC_WAIT: begin
				if (wait_reg >= acc_w) begin
					state_next = brake_seq_pkg::ST_RUN;
					target_next = command_freq;
				end
			end
			brake_seq_pkg::ST_RUN: begin
				target_next = command_freq;
				if (!run_cmd) begin
					state_next = enabled ? brake_seq_pkg::ST_DECEL_BRK :
						brake_seq_pkg::ST_IDLE;
					target_next = enabled ? brk_f : '0;
				end
			end
			brake_seq_pkg::ST_DECEL_BRK: begin
				target_next = brk_f;
				if (output_freq <= brk_f) begin
					release_next = 1'b0;
					state_next = confirm_assigned ?
						brake_seq_pkg::ST_CONF_OFF :
						brake_seq_pkg::ST_STOP_WAIT;
				end
			end
			brake_seq_pkg::ST_CONF_OFF: begin
				if (!brake_confirm_in) begin
					state_next = brake_seq_pkg::ST_STOP_WAIT;
				end else if (wait_reg >= cnf_w) begin
					state_next = brake_seq_pkg::ST_TRIP;
					error_next = 1'b1;
				end
			end
			brake_seq_pkg::ST_STOP_WAIT: begin
				if (wait_reg >= stp_w) begin
					state_next = brake_seq_pkg::ST_IDLE;
					target_next = '0;
				end
			end
			brake_seq_pkg::ST_TRIP: begin
				// A trip drops the brake and the drive until cleared with
				// run removed, so the car cannot restart unattended.
				target_next = '0;
				release_next = 1'b0;
				if (fault_clear && !run_cmd) begin
					state_next = brake_seq_pkg::ST_IDLE;
					error_next = 1'b0;
				end
			end
			default: begin
				state_next = brake_seq_pkg::ST_TRIP;
				error_next = 1'b1;
			end
		endcase
		if (state_next != state_reg) begin
			wait_next = brake_seq_pkg::WAIT_RESET;
			restart = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= brake_seq_pkg::ST_IDLE;
			wait_reg <= brake_seq_pkg::WAIT_RESET;
			target_freq <= '0;
			brake_release_out <= 1'b0;
			brake_error_out <= 1'b0;
		end else if (clock_en) begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			target_freq <= target_next;
			brake_release_out <= release_next;
			brake_error_out <= error_next;
		end
	end

	assign drive_on = state_reg != brake_seq_pkg::ST_IDLE &&
		state_reg != brake_seq_pkg::ST_TRIP;
	assign trip = brake_error_out;
	assign seq_state = state_reg;
endmodule // lift_brake_sequencer

// file: lift_brake_sequencer_assertions.sv
// Checker for the lift brake sequencer, bound to its top module.
// Assumes one clock domain and the one-hot state encoding.
`timescale 1ns/1ps
module brake_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic fault_clear,
	input wire logic [1:0] brake_enable,
	input wire logic [15:0] release_freq,
	input wire logic [15:0] braking_freq,
	input wire logic [15:0] command_freq,
	input wire logic [7:0] output_current,
	input wire logic [7:0] release_current,
	input wire logic [15:0] target_freq,
	input wire logic brake_release_out,
	input wire logic brake_error_out,
	input wire logic trip,
	input wire logic [9:0] seq_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_rel_from_wait: assert property (
		$rose(brake_release_out) |-> $past(seq_state) == 10'h004)
		else $error("release rose outside release wait");
	a_rel_current: assert property (
		$rose(brake_release_out) |->
		$past(output_current) >= $past(release_current))
		else $error("release with low current");
	a_err_in_trip: assert property (
		brake_error_out == seq_state[9] && trip == brake_error_out)
		else $error("error output not tied to trip");
	a_err_holds: assert property (
		brake_error_out && !fault_clear |=> brake_error_out)
		else $error("error dropped without clear");
	a_hold_rel_freq: assert property (
		seq_state[4:1] != 4'h0 |-> target_freq == release_freq)
		else $error("target not release frequency");
	a_brk_freq: assert property (
		seq_state[8:6] != 3'h0 |-> target_freq == braking_freq)
		else $error("target not braking frequency");
	a_rel_drop: assert property (
		$fell(brake_release_out) |->
		brake_error_out || $past(seq_state) == 10'h040)
		else $error("release dropped out of order");
	a_idle_zero: assert property (
		seq_state[0] |-> target_freq == 16'h0000 && !brake_release_out)
		else $error("idle not at zero");
	a_disabled_quiet: assert property (
		brake_enable == 2'h0 |-> !brake_release_out && !brake_error_out)
		else $error("brake outputs while disabled");
	a_run_cmd: assert property (
		seq_state[5] && brake_enable == 2'h1 |->
		target_freq == command_freq)
		else $error("run target not command");
	c_conf_trip: cover property (seq_state[9] && $past(seq_state[3]));
	c_conf_off: cover property (seq_state[7]);
	c_run: cover property (seq_state[5] && brake_release_out);
endmodule // brake_chk
bind lift_brake_sequencer brake_chk chk (
	.clock(clock),
	.reset_n(reset_n),
	.fault_clear(fault_clear),
	.brake_enable(brake_enable),
	.release_freq(release_freq),
	.braking_freq(braking_freq),
	.command_freq(command_freq),
	.output_current(output_current),
	.release_current(release_current),
	.target_freq(target_freq),
	.brake_release_out(brake_release_out),
	.brake_error_out(brake_error_out),
	.trip(trip),
	.seq_state(seq_state)
);

// file: brake_model.sv
// Model of the external brake and its release confirmation contact.
// Assumes the bench drives the stuck control off the falling edge.
`timescale 1ns/1ps
module brake_model (
	input wire logic clock,
	input wire logic release_in,
	input wire logic stuck,
	input wire logic [3:0] delay,
	output logic confirm
);
	logic [3:0] cnt = 4'h0;
	initial confirm = 1'b0;
	// A stuck brake freezes its contact so the confirmation timeouts trip.
	always @(negedge clock) begin
		if (stuck || release_in == confirm)
			cnt <= 4'h0;
		else if (cnt >= delay)
			confirm <= release_in;
		else
			cnt <= cnt + 4'h1;
	end
endmodule // brake_model

// file: tb.sv
// Self-checking bench for the lift brake sequencer with a brake model.
// Assumes a shortened tick divider of ten clock cycles.
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0, reset_n = 1'b0, clock_en = 1'b1;
	logic run_cmd = 1'b0, fault_clear = 1'b0, stuck = 1'b0;
	logic [1:0] brake_enable = 2'h0;
	logic [8:0] release_wait = 9'h000, accel_wait = 9'h000;
	logic [8:0] stop_wait = 9'h000, confirm_wait = 9'h000;
	logic [15:0] release_freq = 16'h0000, braking_freq = 16'h0000;
	logic [15:0] command_freq = 16'h0000, output_freq = 16'h0000;
	logic [7:0] release_current = 8'h50, output_current = 8'h00;
	logic [7:0] input_func [7];
	logic [6:0] input_pins, noise = 7'h00;
	logic [3:0] dly = 4'h0;
	logic confirm, rel_seen, drive_on, brake_release_out;
	logic brake_error_out, trip;
	logic [15:0] target_freq;
	logic [9:0] seq_state;
	int cslot = 7, n_fail = 0, checks = 0;
	int cs [7][4] = '{'{0, 3, 0, 0}, '{1, 7, 0, 0}, '{1, 2, 0, 0},
		'{1, 7, 0, 1}, '{1, 4, 1, 0}, '{1, 6, 2, 0}, '{0, 0, 1, 1}};

	lift_brake_sequencer #(.TICK_DIVIDE(10)) dut (.*);
	brake_model brake (.clock(clock), .release_in(brake_release_out),
		.stuck(stuck), .delay(dly), .confirm(confirm));

	assign input_pins = (noise & ~(7'h01 << cslot)) | (7'(confirm) << cslot);
	initial forever #10 clock = ~clock;
	always @(negedge clock) begin
		noise <= 7'($urandom);
		clock_en <= ($urandom % 8) != 0;
		output_freq <= target_freq;
	end

	task automatic check(logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_for(logic [9:0] st);
		int n;
		n = 0;
		// A trip ends the wait only once the release output has dropped.
		while (seq_state !== st && n < 3000 &&
			!(seq_state[9] === 1'b1 && brake_release_out === 1'b0)) begin
			@(negedge clock);
			rel_seen |= brake_release_out;
			n++;
		end
		check(16'(n < 3000), 16'h0001);
	endtask

	// Slot 7 leaves every terminal without the confirmation function.
	task automatic go(int en, int slot, int st, int low);
		@(negedge clock);
		brake_enable = 2'(en);
		cslot = slot;
		dly = 4'($urandom % 12);
		foreach (input_func[i])
			input_func[i] = i == slot ? 8'h2c : 8'($urandom % 44);
		release_wait = 9'($urandom % 4);
		accel_wait = 9'($urandom % 4);
		stop_wait = 9'($urandom % 4);
		confirm_wait = 9'h002 + 9'($urandom % 3);
		release_freq = 16'($urandom_range(8000, 100));
		braking_freq = 16'($urandom_range(8000, 100));
		command_freq = 16'($urandom_range(40000, 9000));
		output_current = low ? 8'h4f : 8'($urandom_range(200, 80));
		stuck = st == 1;
		rel_seen = 1'b0;
		run_cmd = 1'b1;
		wait_for(10'h020);
		check(16'(rel_seen), 16'(en == 1 && !low));
		check(16'(brake_error_out),
			16'(en == 1 && (low || slot < 7 && st == 1)));
		if (!brake_error_out) begin
			check(target_freq, command_freq);
			check(16'(drive_on), 16'h0001);
		end
		stuck = st == 2;
		run_cmd = 1'b0;
		wait_for(10'h001);
		check(16'(brake_error_out),
			16'(en == 1 && (low || slot < 7 && st != 0)));
		check(16'(brake_release_out), 16'h0000);
		stuck = 1'b0;
		fault_clear = 1'b1;
		repeat (16) @(negedge clock);
		fault_clear = 1'b0;
		check(16'(seq_state), 16'h0001);
		check(16'(drive_on), 16'h0000);
	endtask

	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		foreach (input_func[i])
			input_func[i] = 8'h00;
		void'($urandom(17));
		repeat (10) @(posedge clock);
		@(negedge clock);
		reset_n = 1'b1;
		foreach (cs[i])
			go(cs[i][0], cs[i][1], cs[i][2], cs[i][3]);
		repeat (12)
			go($urandom % 2, $urandom % 8, $urandom % 3, $urandom % 4 == 0);
		complete_run();
	end

	// The tests need well under a tenth of this span.
	initial begin
		#1000000;
		n_fail++;
		complete_run();
	end
endmodule // tb
